// *** design/bcp_pkg.sv ***
package bcp_pkg;
  // Packet layout
  localparam int HDR_BYTES = 4;
  localparam int MAX_PARAMS = 7;
  localparam int PKT_BYTES = 32;
  localparam logic [7:0] RSVD_BYTE = 8'h00;
  localparam int FLAG_DATA_BIT = 0;
  // Framing wrapper types
  localparam logic [7:0] WRAP_TYPE_CMD = 8'hA4;
  localparam logic [7:0] WRAP_TYPE_PAYLOAD = 8'hA5;
  // Command tags
  localparam logic [7:0] TAG_ERASE_WHOLE = 8'h01;
  localparam logic [7:0] TAG_ERASE_RANGE = 8'h02;
  localparam logic [7:0] TAG_MEM_FETCH = 8'h03;
  localparam logic [7:0] TAG_MEM_STORE = 8'h04;
  localparam logic [7:0] TAG_UNLOCK_KEY = 8'h06;
  localparam logic [7:0] TAG_SETTING_QUERY = 8'h07;
  localparam logic [7:0] TAG_EXECUTE = 8'h09;
  localparam logic [7:0] TAG_RESET = 8'h0B;
  localparam logic [7:0] TAG_SETTING_WRITE = 8'h0C;
  localparam logic [7:0] TAG_ERASE_UNLOCK = 8'h0D;
  // Reply tags, reply word counts and command parameter counts
  localparam logic [7:0] TAG_COMMON_REPLY = 8'hA0;
  localparam logic [7:0] TAG_MEM_FETCH_REPLY = 8'hA3;
  localparam logic [7:0] TAG_SETTING_REPLY = 8'hA7;
  localparam logic [2:0] COMMON_REPLY_COUNT = 3'h2;
  localparam logic [2:0] FETCH_REPLY_COUNT = 3'h2;
  localparam logic [2:0] EXECUTE_COUNT = 3'h3;
  localparam logic [2:0] RESET_COUNT = 3'h0;
  // Status codes (values arbitrary)
  localparam logic [31:0] OK_STATUS_CODE = 32'h0000_0000;
  localparam logic [31:0] ERR_UNKNOWN_CMD = 32'h0000_2710;
  localparam logic [31:0] ERR_BAD_ARG = 32'h0000_0004;

  typedef struct packed {
    logic [7:0] tag;
    logic [7:0] flags;
    logic [7:0] count;
  } bcp_hdr_t;

  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] arg;
    logic [31:0] sp;
  } bcp_jump_t;
endpackage

// *** design/bcp_word_asm.sv ***
`timescale 1ns/1ps
// Gathers bytes into a word, least significant byte first
module bcp_word_asm (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Byte input
  input wire logic clear,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  // Word output
  output logic word_done,
  output logic [31:0] word
);
  logic [1:0] lane;

  // Done is registered so that the word is whole when it is flagged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lane <= 2'h0;
      word <= 32'h0000_0000;
      word_done <= 1'b0;
    end else if (clear) begin
      lane <= 2'h0;
      word_done <= 1'b0;
    end else if (byte_valid) begin
      word[lane*8 +: 8] <= byte_data;
      lane <= lane + 2'h1;
      word_done <= (lane == 2'h3);
    end else begin
      word_done <= 1'b0;
    end
  end
endmodule

// *** design/bcp_word_ser.sv ***
`timescale 1ns/1ps
// Sends a word as four bytes, least significant byte first
module bcp_word_ser (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Word input
  input wire logic load,
  input wire logic [31:0] word,
  // Byte output
  input wire logic advance,
  output logic [7:0] byte_data,
  output logic last
);
  logic [31:0] shreg;
  logic [1:0] lane;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg <= 32'h0000_0000;
      lane <= 2'h0;
    end else if (load) begin
      shreg <= word;
      lane <= 2'h0;
    end else if (advance) begin
      shreg <= {8'h00, shreg[31:8]};
      lane <= lane + 2'h1;
    end
  end

  assign byte_data = shreg[7:0];
  assign last = (lane == 2'h3);
endmodule

// *** design/bcp_handler.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Header is tag, flags, zero, count
// - Exactly count parameter words follow header
// - At most seven parameter words
// - Accept listed tags, others are reserved
// - Reply tags A0, A7, A3 used properly
// - Flags bit 0 marks a data phase
// - Data length comes from a parameter word; code fixes unlock key at 8
// - Replies use the command packet layout
// - Data packets raw; direction from last command
// - Each data packet goes in a wrapper
// - Finish with common reply, count two
// - Common reply holds status then command tag
// - Setting reply: status plus one-six values
// - Fetch reply: tag A3, flag, status, count
// - Execute carries pc, argument, stack pointer
// - Execute replies before jumping
// - Execute resets system then loads registers; code requests no reset, only a jump_req pulse with jump_regs
// - Reset has no parameters, no data
// - Reset replies first, then resets chip
// - Multi-byte fields go low byte first
// - Wrapper type A4 command, A5 data
module bcp_handler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Incoming command packet bytes, after unwrapping
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_start,
  input wire logic [7:0] rx_wrap_type,
  // Outgoing reply bytes
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic [7:0] tx_wrap_type,
  // Decoded command to the worker
  output logic cmd_valid,
  output bcp_pkg::bcp_hdr_t cmd_hdr,
  output logic [31:0] cmd_param [bcp_pkg::MAX_PARAMS],
  output logic data_phase,
  output logic data_to_host,
  output logic [31:0] data_len,
  // Worker completion
  input wire logic done_valid,
  input wire logic [31:0] done_status,
  input wire logic [2:0] done_value_count,
  input wire logic [31:0] done_value [6],
  input wire logic [31:0] done_fetch_len,
  // System actions
  output logic jump_req,
  output bcp_pkg::bcp_jump_t jump_regs,
  output logic chip_reset_req
);
  typedef enum logic [5:0] {
    ST_HDR = 6'h01,
    ST_PARAM = 6'h02,
    ST_WORK = 6'h04,
    ST_TX_HDR = 6'h08,
    ST_TX_WORD = 6'h10,
    ST_ACT = 6'h20
  } bcp_state_t;

  bcp_state_t state;
  logic [1:0] hdr_idx;
  logic [2:0] p_idx;
  logic [7:0] reserved_rx;
  logic own_cmd;
  logic [31:0] reply_word [7];
  logic [7:0] reply_tag;
  logic [7:0] reply_flags;
  logic [2:0] reply_count;
  logic [2:0] w_idx;
  logic [1:0] th_idx;
  logic final_sent;
  logic pending_jump;
  logic pending_reset;
  logic [31:0] rx_word;
  logic rx_word_done;
  logic asm_clear;
  logic ser_load;
  logic ser_adv;
  logic [7:0] ser_byte;
  logic ser_last;
  logic tag_known;
  logic bad_count;
  logic in_take;

  always_comb begin
    case (cmd_hdr.tag)
      bcp_pkg::TAG_ERASE_WHOLE, bcp_pkg::TAG_ERASE_RANGE,
      bcp_pkg::TAG_MEM_FETCH, bcp_pkg::TAG_MEM_STORE,
      bcp_pkg::TAG_UNLOCK_KEY, bcp_pkg::TAG_SETTING_QUERY,
      bcp_pkg::TAG_EXECUTE, bcp_pkg::TAG_RESET,
      bcp_pkg::TAG_SETTING_WRITE, bcp_pkg::TAG_ERASE_UNLOCK:
        tag_known = 1'b1;
      default: tag_known = 1'b0;
    endcase
  end

  always_comb begin
    bad_count = (cmd_hdr.count > 8'(bcp_pkg::MAX_PARAMS));
    if (cmd_hdr.tag == bcp_pkg::TAG_EXECUTE) begin
      bad_count = bad_count ||
        (cmd_hdr.count != 8'(bcp_pkg::EXECUTE_COUNT));
    end
    if (cmd_hdr.tag == bcp_pkg::TAG_RESET) begin
      bad_count = bad_count ||
        (cmd_hdr.count != 8'(bcp_pkg::RESET_COUNT)) ||
        cmd_hdr.flags[bcp_pkg::FLAG_DATA_BIT];
    end
    if (reserved_rx != bcp_pkg::RSVD_BYTE) begin
      bad_count = 1'b1;
    end
  end

  // Bytes are only taken while idle or gathering; host waits otherwise
  assign in_take = rx_valid && (state == ST_HDR || state == ST_PARAM) &&
    (rx_wrap_type == bcp_pkg::WRAP_TYPE_CMD);
  assign asm_clear = rx_start || state != ST_PARAM;

  bcp_word_asm u_asm (
    .clk(clk),
    .rst_n(rst_n),
    .clear(asm_clear),
    .byte_valid(in_take && state == ST_PARAM),
    .byte_data(rx_data),
    .word_done(rx_word_done),
    .word(rx_word)
  );

  assign ser_adv = tx_valid && tx_ready && state == ST_TX_WORD;
  assign ser_load = (state == ST_TX_HDR && tx_ready && th_idx == 2'h3) ||
    (ser_adv && ser_last);

  bcp_word_ser u_ser (
    .clk(clk),
    .rst_n(rst_n),
    .load(ser_load),
    .word(state == ST_TX_HDR ? reply_word[0] : reply_word[w_idx + 3'h1]),
    .advance(ser_adv),
    .byte_data(ser_byte),
    .last(ser_last)
  );

  // Command header and parameter capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hdr_idx <= 2'h0;
      p_idx <= 3'h0;
      cmd_hdr <= '0;
      reserved_rx <= 8'h00;
      cmd_param <= '{default: 32'h0000_0000};
    end else if (rx_start && state == ST_HDR) begin
      hdr_idx <= 2'h0;
    end else if (in_take && state == ST_HDR) begin
      case (hdr_idx)
        2'h0: cmd_hdr.tag <= rx_data;
        2'h1: cmd_hdr.flags <= rx_data;
        2'h2: reserved_rx <= rx_data;
        default: cmd_hdr.count <= rx_data;
      endcase
      hdr_idx <= hdr_idx + 2'h1;
      p_idx <= 3'h0;
    end else if (rx_word_done && state == ST_PARAM) begin
      cmd_param[p_idx] <= rx_word;
      p_idx <= p_idx + 3'h1;
    end
  end

  // Sequencing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_HDR;
    end else begin
      case (state)
        ST_HDR: begin
          if (in_take && hdr_idx == 2'h3) begin
            state <= (rx_data == 8'h00) ? ST_WORK : ST_PARAM;
          end
        end
        ST_PARAM: begin
          if (rx_start) begin
            state <= ST_HDR;
          end else if (rx_word_done &&
            ({5'h00, p_idx} + 8'h01 == cmd_hdr.count ||
             p_idx == 3'(bcp_pkg::MAX_PARAMS - 1))) begin
            state <= ST_WORK;
          end
        end
        ST_WORK: begin
          if (own_cmd || done_valid) begin
            state <= ST_TX_HDR;
          end
        end
        ST_TX_HDR: begin
          if (tx_ready && th_idx == 2'h3) begin
            state <= ST_TX_WORD;
          end
        end
        ST_TX_WORD: begin
          if (ser_adv && ser_last && w_idx + 3'h1 == reply_count) begin
            state <= final_sent ? ST_ACT : ST_TX_HDR;
          end
        end
        ST_ACT: state <= ST_HDR;
        default: state <= ST_HDR;
      endcase
    end
  end

  // Reply building
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reply_tag <= bcp_pkg::TAG_COMMON_REPLY;
      reply_flags <= 8'h00;
      reply_count <= 3'h0;
      reply_word <= '{default: 32'h0000_0000};
      final_sent <= 1'b0;
      th_idx <= 2'h0;
      w_idx <= 3'h0;
    end else begin
      if (state == ST_WORK && (own_cmd || done_valid)) begin
        th_idx <= 2'h0;
        w_idx <= 3'h0;
        if (!tag_known || bad_count) begin
          reply_tag <= bcp_pkg::TAG_COMMON_REPLY;
          reply_flags <= 8'h00;
          reply_count <= bcp_pkg::COMMON_REPLY_COUNT;
          reply_word[0] <= tag_known ? bcp_pkg::ERR_BAD_ARG :
            bcp_pkg::ERR_UNKNOWN_CMD;
          reply_word[1] <= {24'h000000, cmd_hdr.tag};
          final_sent <= 1'b1;
        end else if (cmd_hdr.tag == bcp_pkg::TAG_SETTING_QUERY &&
          done_status == bcp_pkg::OK_STATUS_CODE &&
          done_value_count != 3'h0) begin
          reply_tag <= bcp_pkg::TAG_SETTING_REPLY;
          reply_flags <= 8'h00;
          reply_count <= (done_value_count > 3'h6 ? 3'h6 :
            done_value_count) + 3'h1;
          reply_word[0] <= done_status;
          for (int i = 0; i < 6; i++) begin
            reply_word[i+1] <= done_value[i];
          end
          final_sent <= 1'b1;
        end else if (cmd_hdr.tag == bcp_pkg::TAG_MEM_FETCH &&
          !final_sent && done_status == bcp_pkg::OK_STATUS_CODE) begin
          reply_tag <= bcp_pkg::TAG_MEM_FETCH_REPLY;
          reply_flags <= 8'h01;
          reply_count <= bcp_pkg::FETCH_REPLY_COUNT;
          reply_word[0] <= done_status;
          reply_word[1] <= done_fetch_len;
          final_sent <= 1'b0;
        end else begin
          reply_tag <= bcp_pkg::TAG_COMMON_REPLY;
          reply_flags <= 8'h00;
          reply_count <= bcp_pkg::COMMON_REPLY_COUNT;
          reply_word[0] <= own_cmd ? bcp_pkg::OK_STATUS_CODE :
            done_status;
          reply_word[1] <= {24'h000000, cmd_hdr.tag};
          final_sent <= 1'b1;
        end
      end else if (state == ST_TX_HDR && tx_ready) begin
        th_idx <= th_idx + 2'h1;
      end else if (ser_adv && ser_last) begin
        w_idx <= w_idx + 3'h1;
        if (w_idx + 3'h1 == reply_count && !final_sent) begin
          // Fetch reply sent; common reply follows at once, without waiting for a data phase
          final_sent <= 1'b1;
          reply_tag <= bcp_pkg::TAG_COMMON_REPLY;
          reply_flags <= 8'h00;
          reply_count <= bcp_pkg::COMMON_REPLY_COUNT;
          reply_word[1] <= {24'h000000, cmd_hdr.tag};
          th_idx <= 2'h0;
          w_idx <= 3'h0;
        end
      end else if (state == ST_HDR) begin
        final_sent <= 1'b0;
      end
    end
  end

  // Execute and reset are handled here; pending until the reply is out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_jump <= 1'b0;
      pending_reset <= 1'b0;
      jump_req <= 1'b0;
      chip_reset_req <= 1'b0;
      jump_regs <= '0;
    end else begin
      jump_req <= 1'b0;
      if (state == ST_WORK && own_cmd && tag_known && !bad_count) begin
        pending_jump <= (cmd_hdr.tag == bcp_pkg::TAG_EXECUTE);
        pending_reset <= (cmd_hdr.tag == bcp_pkg::TAG_RESET);
        jump_regs.pc <= cmd_param[0];
        jump_regs.arg <= cmd_param[1];
        jump_regs.sp <= cmd_param[2];
      end else if (state == ST_WORK) begin
        pending_jump <= 1'b0;
        pending_reset <= 1'b0;
      end
      if (state == ST_ACT) begin
        jump_req <= pending_jump;
        chip_reset_req <= chip_reset_req | pending_reset;
        pending_jump <= 1'b0;
        pending_reset <= 1'b0;
      end
    end
  end

  // Worker interface
  logic worker_cmd;
  assign worker_cmd = (cmd_hdr.tag != bcp_pkg::TAG_EXECUTE) &&
    (cmd_hdr.tag != bcp_pkg::TAG_RESET) && tag_known && !bad_count;
  // Execute, reset and refused commands are answered without the worker
  assign own_cmd = !worker_cmd;
  assign cmd_valid = (state == ST_WORK) && worker_cmd && !own_cmd;
  assign data_phase = cmd_hdr.flags[bcp_pkg::FLAG_DATA_BIT];
  assign data_to_host = (cmd_hdr.tag == bcp_pkg::TAG_MEM_FETCH);
  always_comb begin
    case (cmd_hdr.tag)
      bcp_pkg::TAG_MEM_STORE, bcp_pkg::TAG_MEM_FETCH:
        data_len = cmd_param[1];
      bcp_pkg::TAG_UNLOCK_KEY: data_len = 32'h0000_0008;
      default: data_len = 32'h0000_0000;
    endcase
  end

  // Transmit byte stream
  always_comb begin
    tx_valid = (state == ST_TX_HDR) || (state == ST_TX_WORD);
    tx_wrap_type = bcp_pkg::WRAP_TYPE_CMD;
    tx_last = (state == ST_TX_WORD) && ser_last &&
      (w_idx + 3'h1 == reply_count);
    case (th_idx)
      2'h0: tx_data = reply_tag;
      2'h1: tx_data = reply_flags;
      2'h2: tx_data = bcp_pkg::RSVD_BYTE;
      default: tx_data = {5'h00, reply_count};
    endcase
    if (state == ST_TX_WORD) begin
      tx_data = ser_byte;
    end
  end
endmodule

// *** tb/bcp_handler_asserts.sv ***
`timescale 1ns/1ps
module bcp_handler_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Packet traffic
  input wire logic rx_valid,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic [7:0] tx_wrap_type,
  // Actions
  input wire logic cmd_valid,
  input wire logic jump_req,
  input wire logic chip_reset_req
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic hs;
  logic seen_last;
  logic [5:0] idx;
  logic [7:0] tag0;
  logic [7:0] cnt;
  assign hs = tx_valid && tx_ready;
  // Byte position in the reply, its tag and word count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 6'h00;
      tag0 <= 8'h00;
      cnt <= 8'h00;
    end else if (hs) begin
      idx <= tx_last ? 6'h00 : idx + 6'h01;
      if (idx == 6'h00)
        tag0 <= tx_data;
      if (idx == 6'h03)
        cnt <= tx_data;
    end
  end
  // A reply has ended since the last command byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      seen_last <= 1'b0;
    else if (hs && tx_last)
      seen_last <= 1'b1;
    else if (rx_valid)
      seen_last <= 1'b0;
  end
  a_wrap_cmd_type: assert property (tx_valid |-> tx_wrap_type == 8'hA4)
    else $error("reply wrapper type wrong");
  a_byte_holds: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("reply byte changed before taken");
  a_reply_tag: assert property (tx_valid && idx == 6'h00 |->
      tx_data inside {8'hA0, 8'hA3, 8'hA7})
    else $error("reply tag not a reply code");
  a_rsvd_zero: assert property (tx_valid && idx == 6'h02 |->
      tx_data == 8'h00)
    else $error("reply reserved byte not zero");
  a_reply_length: assert property (hs && tx_last |->
      cnt <= 8'h07 && int'(idx) == 3 + 4 * int'(cnt))
    else $error("reply length disagrees with count");
  a_common_count: assert property (tx_valid && idx == 6'h03 &&
      tag0 == 8'hA0 |-> tx_data == 8'h02)
    else $error("common reply count not two");
  a_reset_after: assert property ($rose(chip_reset_req) |-> seen_last)
    else $error("chip reset before reply ended");
  a_reset_sticky: assert property (chip_reset_req |=> chip_reset_req)
    else $error("chip reset request dropped");
  a_jump_after: assert property ($rose(jump_req) |->
      seen_last ##1 !jump_req)
    else $error("jump not a pulse after reply");
  a_idle_replying: assert property (tx_valid |-> !cmd_valid)
    else $error("reply while command pending");
endmodule
bind bcp_handler bcp_handler_asserts u_chk (.clk, .rst_n, .rx_valid,
  .tx_valid, .tx_ready, .tx_data, .tx_last, .tx_wrap_type, .cmd_valid,
  .jump_req, .chip_reset_req);

// *** tb/bcp_host_model.sv ***
`timescale 1ns/1ps
module bcp_host_model (
  // Clock
  input wire logic clk,
  // Command bytes toward the target
  output logic rx_valid,
  output logic rx_start,
  output logic [7:0] rx_data,
  output logic [7:0] rx_wrap_type,
  // Reply bytes from the target
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  logic slow = 1'b0;
  logic [7:0] wrap = 8'hA4;
  logic [1:0] gap = 2'h0;
  logic [7:0] got_q [$];
  int n_last = 0;
  initial begin
    rx_valid = 1'b0;
    rx_start = 1'b0;
    rx_data = 8'h5A;
    rx_wrap_type = 8'hA4;
  end
  // Slow mode takes one reply byte in four
  assign tx_ready = !slow || gap == 2'h3;
  always @(negedge clk)
    gap <= gap + 2'h1;
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      got_q.push_back(tx_data);
      if (tx_last)
        n_last++;
    end
  end
  // Header then words low byte first, at most 32 bytes
  // Caller waits for the reply before sending again
  task automatic send(input logic [7:0] b [$]);
    @(negedge clk);
    rx_start = 1'b1;
    rx_wrap_type = wrap;
    @(negedge clk);
    rx_start = 1'b0;
    foreach (b[i]) begin
      rx_valid = 1'b1;
      rx_data = b[i];
      @(negedge clk);
    end
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask
endmodule

// *** tb/bcp_handler_test.sv ***
`timescale 1ns/1ps
module bcp_handler_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_valid, rx_start, tx_valid, tx_ready, tx_last, cmd_valid;
  logic data_phase, data_to_host, jump_req, chip_reset_req;
  logic [7:0] rx_data, rx_wrap_type, tx_data, tx_wrap_type;
  logic [31:0] data_len;
  logic [31:0] cmd_param [bcp_pkg::MAX_PARAMS];
  bcp_pkg::bcp_hdr_t cmd_hdr;
  bcp_pkg::bcp_jump_t jump_regs;
  logic done_valid = 1'b0;
  logic [31:0] done_status = 32'h0;
  logic [2:0] done_value_count = 3'h0;
  logic [31:0] done_value [6] = '{default: 32'h0};
  logic [31:0] done_fetch_len = 32'h0;
  logic [31:0] p [7] = '{default: 32'h0};
  logic [7:0] rsvd [7] = '{8'h05, 8'h08, 8'h0A, 8'h0E, 8'h0F, 8'h10, 8'h11};
  logic [7:0] wk [6] = '{8'h01, 8'h02, 8'h04, 8'h06, 8'h0C, 8'h0D};
  logic [7:0] exp_q [$];
  int n_mismatch = 0;
  int checked = 0;
  int n_jump = 0;
  always #10 clk = ~clk;
  always @(posedge clk)
    if (jump_req === 1'b1)
      n_jump++;
  bcp_handler DUT (.clk, .rst_n, .rx_valid, .rx_data, .rx_start,
    .rx_wrap_type, .tx_valid, .tx_ready, .tx_data, .tx_last, .tx_wrap_type,
    .cmd_valid, .cmd_hdr, .cmd_param, .data_phase, .data_to_host, .data_len,
    .done_valid, .done_status, .done_value_count, .done_value,
    .done_fetch_len, .jump_req, .jump_regs, .chip_reset_req);
  bcp_host_model host (.clk, .rx_valid, .rx_start, .rx_data, .rx_wrap_type,
    .tx_valid, .tx_data, .tx_last, .tx_ready);
  task automatic summarize();
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
      input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic word(input logic [31:0] w);
    for (int k = 0; k < 4; k++)
      exp_q.push_back(w[8*k +: 8]);
  endtask
  task automatic common(input logic [31:0] st, input logic [7:0] t);
    exp_q = {exp_q, 8'hA0, 8'h00, 8'h00, 8'h02};
    word(st);
    word({24'h0, t});
  endtask
  task automatic cmd(input logic [7:0] t, f, c);
    logic [7:0] b [$];
    b = {t, f, 8'h00, c};
    for (int i = 0; i < c; i++)
      for (int k = 0; k < 4; k++)
        b.push_back(p[i][8*k +: 8]);
    host.got_q.delete();
    host.n_last = 0;
    exp_q.delete();
    host.send(b);
  endtask
  task automatic reply(input int npk);
    int t;
    t = 0;
    while (host.n_last < npk && t < 3000) begin
      @(negedge clk);
      t++;
    end
    chk("reply packets", npk, host.n_last);
    chk("reply length", exp_q.size(), host.got_q.size());
    foreach (exp_q[i])
      chk("reply byte", exp_q[i], host.got_q[i]);
  endtask
  task automatic finish(input logic [31:0] st, input logic [2:0] n,
      input logic [31:0] fl);
    int t;
    t = 0;
    while (cmd_valid !== 1'b1 && t < 200) begin
      @(negedge clk);
      t++;
    end
    chk("cmd valid", 32'h1, {31'h0, cmd_valid});
    done_status = st;
    done_value_count = n;
    done_fetch_len = fl;
    done_valid = 1'b1;
    @(negedge clk);
    done_valid = 1'b0;
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
  endtask
  initial begin
    do_reset();
    cmd(8'h0B, 8'h00, 8'h00);
    common(32'h0, 8'h0B);
    reply(1);
    repeat (3) @(negedge clk);
    chk("chip reset", 32'h1, {31'h0, chip_reset_req});
    do_reset();
    p[0] = 32'h0000_8001;
    p[1] = 32'h1234_5678;
    p[2] = 32'h2000_3FF0;
    host.slow = 1'b1;
    cmd(8'h09, 8'h00, 8'h03);
    common(32'h0, 8'h09);
    reply(1);
    host.slow = 1'b0;
    repeat (3) @(negedge clk);
    chk("jump count", 32'h1, n_jump);
    chk("jump pc", p[0], jump_regs.pc);
    chk("jump arg", p[1], jump_regs.arg);
    chk("jump sp", p[2], jump_regs.sp);
    do_reset();
    cmd(8'h09, 8'h00, 8'h02);
    common(bcp_pkg::ERR_BAD_ARG, 8'h09);
    reply(1);
    cmd(8'h0B, 8'h01, 8'h00);
    common(bcp_pkg::ERR_BAD_ARG, 8'h0B);
    reply(1);
    repeat (3) @(negedge clk);
    chk("jump count", 32'h1, n_jump);
    chk("chip reset", 32'h0, {31'h0, chip_reset_req});
    foreach (rsvd[i]) begin
      cmd(rsvd[i], 8'h00, 8'h00);
      common(bcp_pkg::ERR_UNKNOWN_CMD, rsvd[i]);
      reply(1);
    end
    foreach (wk[i]) begin
      p[0] = 32'hA5C3_0000 | wk[i];
      p[1] = 32'h0000_0100;
      cmd(wk[i], {7'h0, wk[i] == 8'h04}, 8'h02);
      finish({24'h0, wk[i]}, 3'h0, 32'h0);
      chk("cmd tag", wk[i], cmd_hdr.tag);
      chk("param 0", p[0], cmd_param[0]);
      chk("data phase", wk[i] == 8'h04, data_phase);
      chk("to host", 32'h0, {31'h0, data_to_host});
      if (wk[i] == 8'h04)
        chk("data len", p[1], data_len);
      common({24'h0, wk[i]}, wk[i]);
      reply(1);
    end
    p[0] = 32'h0000_0400;
    p[1] = 32'h0000_0040;
    cmd(8'h03, 8'h00, 8'h02);
    finish(32'h0, 3'h0, p[1]);
    chk("to host", 32'h1, {31'h0, data_to_host});
    chk("data len", p[1], data_len);
    exp_q = {exp_q, 8'hA3, 8'h01, 8'h00, 8'h02};
    word(32'h0);
    word(p[1]);
    common(32'h0, 8'h03);
    reply(2);
    cmd(8'h03, 8'h00, 8'h02);
    finish(bcp_pkg::ERR_BAD_ARG, 3'h0, p[1]);
    common(bcp_pkg::ERR_BAD_ARG, 8'h03);
    reply(1);
    done_value[0] = 32'h0000_014B;
    done_value[1] = 32'hC0DE_0002;
    cmd(8'h07, 8'h00, 8'h01);
    finish(32'h0, 3'h2, 32'h0);
    exp_q = {exp_q, 8'hA7, 8'h00, 8'h00, 8'h03};
    word(32'h0);
    word(done_value[0]);
    word(done_value[1]);
    reply(1);
    cmd(8'h07, 8'h00, 8'h01);
    finish(32'h0, 3'h0, 32'h0);
    common(32'h0, 8'h07);
    reply(1);
    host.wrap = 8'hA5;
    cmd(8'h0B, 8'h00, 8'h00);
    repeat (40) @(negedge clk);
    host.wrap = 8'hA4;
    chk("ignored reply", 32'h0, host.got_q.size());
    chk("chip reset", 32'h0, {31'h0, chip_reset_req});
    summarize();
  end
  initial begin
    #400_000;
    n_mismatch++;
    summarize();
  end
endmodule
